//--- rtl/udr_pkg.sv
package udr_pkg;
    localparam int UID_W = 48;
    localparam int UID_BYTES = 6;
    localparam int ENC_PAIRS = 8;
    localparam int PREAMBLE_LEN = 7;
    localparam int REPLY_LEN = 24;
    localparam int SUM_START = 20;
    localparam int ACK_LEN = 2;
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int WINDOW_CYC = 64;
    localparam logic [5:0] LEAF_LEVEL = 6'h30;
    localparam logic [7:0] PREAMBLE_BYTE = 8'hfe;
    localparam logic [7:0] SEPARATOR_BYTE = 8'haa;
    localparam logic [7:0] ENC_FIRST = 8'haa;
    localparam logic [7:0] ENC_SECOND = 8'h55;
    localparam logic [7:0] ACK_BYTE = 8'h00;
    localparam logic [7:0] PROBE_PARAM_LEN = 8'h0c;
    localparam logic [7:0] NO_PARAM_LEN = 8'h00;
    localparam logic [15:0] ROOT_SUB = 16'h0000;
    localparam logic [47:0] BROADCAST_TARGET_ADDRESS = 48'hffff_ffff_ffff;
    localparam logic [47:0] EVERY_NODE_ADDRESS = BROADCAST_TARGET_ADDRESS;
    localparam logic [31:0] BCAST_DEVICE_PART = 32'hffff_ffff;
    localparam logic [47:0] UID_TOP_BIT = 48'h8000_0000_0000;
    typedef enum logic [1:0] {
        RANGE_PROBE_COMMAND = 2'h0,
        SILENCE_COMMAND = 2'h1,
        UNSILENCE_COMMAND = 2'h2,
        RESET_DEVICE_COMMAND = 2'h3
    } udr_cmd_t;
endpackage

//--- rtl/udr_link_if.sv
`timescale 1ns/1ps
interface udr_link_if;
    import udr_pkg::*;
    logic cmd_valid;
    logic cmd_ready;
    udr_cmd_t cmd_code;
    logic [47:0] cmd_dest;
    logic [15:0] cmd_sub;
    logic [7:0] cmd_plen;
    logic [47:0] cmd_lower;
    logic [47:0] cmd_upper;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_data;
    logic rsp_last;
    logic line_active;
    modport responder (
        input cmd_valid, cmd_code, cmd_dest, cmd_sub, cmd_plen, cmd_lower, cmd_upper, rsp_ready,
        output cmd_ready, rsp_valid, rsp_data, rsp_last, line_active
    );
    modport controller (
        output cmd_valid, cmd_code, cmd_dest, cmd_sub, cmd_plen, cmd_lower, cmd_upper, rsp_ready,
        input cmd_ready, rsp_valid, rsp_data, rsp_last, line_active
    );
endinterface

//--- rtl/udr_fifo.sv
`timescale 1ns/1ps
module udr_fifo #(
    parameter int WIDTH = udr_pkg::FIFO_WIDTH,
    parameter int DEPTH = udr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("udr_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate
    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = count_reg != (AW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem_reg[rd_reg];
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_reg <= wr_reg + AW'(push);
            rd_reg <= rd_reg + AW'(pop);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- rtl/udr_responder.sv
`timescale 1ns/1ps
module udr_responder (
    input wire logic clk,
    input wire logic rst_n,
    udr_link_if.responder link,
    input wire logic [47:0] uid,
    input wire logic soft_reset,
    output logic muted,
    output logic reply_busy
);
    import udr_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROBE = 2'b01,
        ST_ACK = 2'b11
    } udr_rsp_state_t;
    udr_rsp_state_t state_reg;
    udr_rsp_state_t state_next;
    logic [4:0] slot_reg;
    logic [4:0] slot_next;
    logic muted_reg;
    logic muted_next;
    logic cmd_ready_reg;
    logic line_active_reg;
    logic [7:0] enc_byte [0:2*UID_BYTES-1];
    logic [15:0] part_sum [0:UID_BYTES];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [8:0] fifo_out;

    // Encoded identifier, most significant byte first, and its running sum
    assign part_sum[0] = 16'h0000;
    for (genvar i = 0; i < UID_BYTES; i++) begin : g_enc
        assign enc_byte[2*i] = uid[47-8*i -: 8] | ENC_FIRST;
        assign enc_byte[2*i+1] = uid[47-8*i -: 8] | ENC_SECOND;
        assign part_sum[i+1] = part_sum[i] + {8'h00, enc_byte[2*i]} + {8'h00, enc_byte[2*i+1]};
    end
    wire [15:0] check_sum = part_sum[UID_BYTES];

    wire cmd_take = link.cmd_valid && cmd_ready_reg;
    wire is_root = link.cmd_sub == ROOT_SUB;
    wire to_me = link.cmd_dest == uid;
    wire to_all = link.cmd_dest[31:0] == BCAST_DEVICE_PART
        && (link.cmd_dest[47:32] == BROADCAST_TARGET_ADDRESS[47:32]
        || link.cmd_dest[47:32] == uid[47:32]);
    wire in_range = uid >= link.cmd_lower && uid <= link.cmd_upper;
    wire probe_hit = cmd_take && is_root && link.cmd_code == RANGE_PROBE_COMMAND
        && link.cmd_dest == EVERY_NODE_ADDRESS && link.cmd_plen == PROBE_PARAM_LEN
        && !muted_reg && in_range;
    wire silence_hit = cmd_take && is_root && link.cmd_code == SILENCE_COMMAND
        && (to_me || to_all);
    wire unsilence_hit = cmd_take && is_root && link.cmd_code == UNSILENCE_COMMAND
        && (to_me || to_all);
    wire reset_hit = cmd_take && link.cmd_code == RESET_DEVICE_COMMAND && (to_me || to_all);
    wire mute_clear = soft_reset || unsilence_hit || reset_hit;
    // A silence arriving with a clear keeps the flag set
    assign muted_next = silence_hit || (muted_reg && !mute_clear);

    // Reply slots: preamble, separator, encoded identifier, encoded sum
    wire [3:0] enc_idx = 4'(slot_reg - 5'(PREAMBLE_LEN + 1));
    wire [1:0] sum_idx = 2'(slot_reg - 5'(SUM_START));
    wire [7:0] sum_half = sum_idx[1] ? check_sum[7:0] : check_sum[15:8];
    wire [7:0] sum_byte = sum_half | (sum_idx[0] ? ENC_SECOND : ENC_FIRST);
    wire [7:0] probe_byte = (slot_reg < 5'(PREAMBLE_LEN)) ? PREAMBLE_BYTE :
        (slot_reg == 5'(PREAMBLE_LEN)) ? SEPARATOR_BYTE :
        (slot_reg < 5'(SUM_START)) ? enc_byte[enc_idx] : sum_byte;
    wire gen_valid = state_reg != ST_IDLE;
    wire [7:0] gen_byte = (state_reg == ST_PROBE) ? probe_byte : ACK_BYTE;
    wire [4:0] last_slot = (state_reg == ST_PROBE) ? 5'(REPLY_LEN - 1) : 5'(ACK_LEN - 1);
    wire gen_last = slot_reg == last_slot;

    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        case (state_reg)
            ST_IDLE: begin
                slot_next = 5'h00;
                if (probe_hit) begin
                    state_next = ST_PROBE;
                end else if ((silence_hit || unsilence_hit) && to_me) begin
                    state_next = ST_ACK;
                end
            end
            ST_PROBE, ST_ACK: begin
                if (fifo_in_ready) begin
                    slot_next = slot_reg + 5'h01;
                    if (gen_last) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            slot_reg <= 5'h00;
            muted_reg <= 1'b0;
            cmd_ready_reg <= 1'b0;
            line_active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            muted_reg <= muted_next;
            cmd_ready_reg <= state_next == ST_IDLE;
            // Transmitter on for the whole reply, no break first
            line_active_reg <= (state_next != ST_IDLE) || fifo_out_valid;
        end
    end

    udr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(gen_valid),
        .in_data({gen_last, gen_byte}),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out),
        .out_ready(link.rsp_ready)
    );

    assign link.cmd_ready = cmd_ready_reg;
    assign link.rsp_valid = fifo_out_valid;
    assign link.rsp_data = fifo_out[7:0];
    assign link.rsp_last = fifo_out[8];
    assign link.line_active = line_active_reg;
    assign muted = muted_reg;
    assign reply_busy = line_active_reg;
endmodule

//--- rtl/udr_controller.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Responder keeps one silence flag per port.
// - Reset, unsilence or reset command clears flag.
// - Answer probe only unsilenced and inside bounds.
// - Every command goes to root, sub zero.
// - Range probe always sent to every node.
// - Probe carries twelve bytes: lower, upper bound.
// - Probe reply starts without break.
// - Reply has no header or start code.
// - Seven 0xfe preamble bytes, then 0xaa.
// - UID bytes MSB first, doubled with ORs.
// - Sixteen-bit sum of encoded bytes, doubled.
// - In-line repeater trims at most one slot.
// - Accept zero to seven preamble bytes.
// - Any line activity in window is reply.
// - Full discovery starts with broadcast unsilence.
// - Good sum: silence, reprobe; bad: split branch.
// - Single-UID branch gets silence, not probe.
// - Device silenced by own UID replies, then stops probing answers.
// - Walk tree right to left, continue unchecked.
// - Silence to own UID or broadcast sets flag.
// - Decode pairs by AND, verify recovered sum.
module udr_controller #(
    parameter int WINDOW_CYC = udr_pkg::WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    udr_link_if.controller link,
    input wire logic start,
    input wire logic rsp_stall,
    output logic found_valid,
    output logic [47:0] found_uid,
    output logic busy,
    output logic done
);
    import udr_pkg::*;
    localparam int STACK_DEPTH = int'(LEAF_LEVEL) + 1;
    localparam int TW = $clog2(WINDOW_CYC + 1);
    generate
        if (WINDOW_CYC < 1) begin
            $error("udr_controller: WINDOW_CYC must be at least 1");
        end
    endgenerate
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_UNSIL = 3'b001,
        C_POP = 3'b011,
        C_PROBE = 3'b010,
        C_LISTEN = 3'b110,
        C_MUTE = 3'b111,
        C_MWAIT = 3'b101,
        C_DONE = 3'b100
    } udr_ctl_state_t;
    udr_ctl_state_t state_reg;
    udr_ctl_state_t state_next;
    logic [47:0] lo_stk [0:STACK_DEPTH-1];
    logic [5:0] lvl_stk [0:STACK_DEPTH-1];
    logic [5:0] sp_reg;
    logic [47:0] cur_lo_reg;
    logic [5:0] cur_lvl_reg;
    logic [47:0] target_reg;
    logic reprobe_reg;
    logic cmd_valid_reg;
    logic [TW-1:0] timer_reg;
    logic heard_reg;
    logic acked_reg;
    logic sep_reg;
    logic [3:0] pre_reg;
    logic [4:0] nb_reg;
    logic bad_reg;
    logic [15:0] esum_reg;
    logic [7:0] half_reg;
    logic [63:0] dec_reg;
    logic rsp_ready_reg;
    logic found_valid_reg;
    logic [47:0] found_uid_reg;
    logic busy_reg;
    logic done_reg;

    wire cmd_take = cmd_valid_reg && link.cmd_ready;
    wire byte_take = link.rsp_valid && rsp_ready_reg;
    wire listening = state_reg == C_LISTEN || state_reg == C_MWAIT;
    wire [47:0] cur_hi = cur_lo_reg | (EVERY_NODE_ADDRESS >> cur_lvl_reg);
    wire [47:0] right_lo = cur_lo_reg | (UID_TOP_BIT >> cur_lvl_reg);
    wire [5:0] top_idx = sp_reg - 6'h01;
    wire [47:0] top_lo = lo_stk[top_idx];
    wire [5:0] top_lvl = lvl_stk[top_idx];
    wire window_over = timer_reg >= TW'(WINDOW_CYC)
        && !link.line_active && !link.rsp_valid;
    wire reply_good = sep_reg && !bad_reg && nb_reg == 5'(2 * ENC_PAIRS)
        && dec_reg[15:0] == esum_reg;
    wire push_root = state_reg == C_IDLE && start;
    wire pop_now = state_reg == C_POP && sp_reg != 6'h00;
    wire listen_end = state_reg == C_LISTEN && window_over;
    wire split = listen_end && heard_reg && !reply_good;
    wire got_uid = listen_end && heard_reg && reply_good;

    // Reply parser: preamble, separator, then pairs recovered by AND
    wire [7:0] rx = link.rsp_data;
    wire parse = byte_take && state_reg == C_LISTEN;
    wire is_sep = !sep_reg && rx == SEPARATOR_BYTE;
    wire pre_ok = !sep_reg && rx == PREAMBLE_BYTE && pre_reg < 4'(PREAMBLE_LEN);
    wire body_ok = sep_reg && nb_reg < 5'(2 * ENC_PAIRS);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            C_IDLE: begin
                if (start) begin
                    state_next = C_UNSIL;
                end
            end
            C_UNSIL: begin
                if (cmd_take) begin
                    state_next = C_POP;
                end
            end
            C_POP: begin
                if (sp_reg == 6'h00) begin
                    state_next = C_DONE;
                end else if (top_lvl == LEAF_LEVEL) begin
                    state_next = C_MUTE;
                end else begin
                    state_next = C_PROBE;
                end
            end
            C_PROBE: begin
                if (cmd_take) begin
                    state_next = C_LISTEN;
                end
            end
            C_LISTEN: begin
                if (window_over) begin
                    state_next = got_uid ? C_MUTE : C_POP;
                end
            end
            C_MUTE: begin
                if (cmd_take) begin
                    state_next = C_MWAIT;
                end
            end
            C_MWAIT: begin
                if (window_over) begin
                    state_next = reprobe_reg ? C_PROBE : C_POP;
                end
            end
            C_DONE: begin
                state_next = C_IDLE;
            end
            default: begin
                state_next = C_IDLE;
            end
        endcase
    end

    // Right child is pushed last so it is searched first
    always_ff @(posedge clk) begin
        if (push_root) begin
            lo_stk[0] <= '0;
            lvl_stk[0] <= 6'h00;
        end
        if (split) begin
            lo_stk[sp_reg] <= cur_lo_reg;
            lvl_stk[sp_reg] <= cur_lvl_reg + 6'h01;
            lo_stk[sp_reg + 6'h01] <= right_lo;
            lvl_stk[sp_reg + 6'h01] <= cur_lvl_reg + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= C_IDLE;
            sp_reg <= 6'h00;
            cur_lo_reg <= '0;
            cur_lvl_reg <= 6'h00;
            target_reg <= '0;
            reprobe_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (push_root) begin
                sp_reg <= 6'h01;
            end else if (pop_now) begin
                sp_reg <= top_idx;
            end else if (split) begin
                sp_reg <= sp_reg + 6'h02;
            end
            if (pop_now) begin
                cur_lo_reg <= top_lo;
                cur_lvl_reg <= top_lvl;
                target_reg <= top_lo;
                reprobe_reg <= 1'b0;
            end else if (got_uid) begin
                target_reg <= dec_reg[63:16];
                reprobe_reg <= 1'b1;
            end
            cmd_valid_reg <= state_next == C_UNSIL || state_next == C_PROBE
                || state_next == C_MUTE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || cmd_take) begin
            timer_reg <= '0;
            heard_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else if (listening) begin
            if (timer_reg != TW'(WINDOW_CYC)) begin
                timer_reg <= timer_reg + TW'(1);
            end
            if (link.line_active || link.rsp_valid) begin
                heard_reg <= 1'b1;
            end
            if (state_reg == C_MWAIT && byte_take && link.rsp_last) begin
                acked_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || cmd_take) begin
            sep_reg <= 1'b0;
            pre_reg <= 4'h0;
            nb_reg <= 5'h00;
            bad_reg <= 1'b0;
            esum_reg <= 16'h0000;
        end else if (parse) begin
            sep_reg <= sep_reg || is_sep;
            if (pre_ok) begin
                pre_reg <= pre_reg + 4'h1;
            end
            if (!is_sep && !pre_ok && !body_ok) begin
                bad_reg <= 1'b1;
            end
            if (body_ok) begin
                nb_reg <= nb_reg + 5'h01;
                if (nb_reg < 5'(2 * UID_BYTES)) begin
                    esum_reg <= esum_reg + {8'h00, rx};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (parse && body_ok) begin
            if (!nb_reg[0]) begin
                half_reg <= rx;
            end else begin
                dec_reg <= {dec_reg[55:0], half_reg & rx};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_ready_reg <= 1'b0;
            found_valid_reg <= 1'b0;
            found_uid_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            rsp_ready_reg <= !rsp_stall;
            found_valid_reg <= state_reg == C_MWAIT && window_over && acked_reg;
            if (state_reg == C_MWAIT && window_over && acked_reg) begin
                found_uid_reg <= target_reg;
            end
            busy_reg <= state_next != C_IDLE;
            done_reg <= state_reg == C_DONE;
        end
    end

    assign link.cmd_valid = cmd_valid_reg;
    assign link.cmd_code = (state_reg == C_UNSIL) ? UNSILENCE_COMMAND :
        (state_reg == C_MUTE) ? SILENCE_COMMAND : RANGE_PROBE_COMMAND;
    assign link.cmd_dest = (state_reg == C_UNSIL) ? BROADCAST_TARGET_ADDRESS :
        (state_reg == C_MUTE) ? target_reg : EVERY_NODE_ADDRESS;
    assign link.cmd_sub = ROOT_SUB;
    assign link.cmd_plen = (state_reg == C_PROBE) ? PROBE_PARAM_LEN : NO_PARAM_LEN;
    assign link.cmd_lower = cur_lo_reg;
    assign link.cmd_upper = cur_hi;
    assign link.rsp_ready = rsp_ready_reg;
    assign found_valid = found_valid_reg;
    assign found_uid = found_uid_reg;
    assign busy = busy_reg;
    assign done = done_reg;
endmodule

//--- bench/udr_checker.sv
`timescale 1ns/1ps
module udr_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire udr_pkg::udr_cmd_t cmd_code,
    input wire logic [47:0] cmd_dest,
    input wire logic [15:0] cmd_sub,
    input wire logic [7:0] cmd_plen,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic line_active
);
    import udr_pkg::*;
    // Slot index of the next reply byte taken by the controller
    logic [4:0] idx_reg;
    logic [4:0] idx_next;
    wire take = rsp_valid && rsp_ready;
    wire [7:0] enc_mask = idx_reg[0] ? ENC_SECOND : ENC_FIRST;
    assign idx_next = !take ? idx_reg : (rsp_last ? 5'h00 : idx_reg + 5'h01);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_reg <= 5'h00;
        end else begin
            idx_reg <= idx_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_probe_take;
        cmd_valid && cmd_ready && cmd_code == RANGE_PROBE_COMMAND;
    endsequence
    sequence s_mute_take;
        cmd_valid && cmd_ready && cmd_code == SILENCE_COMMAND;
    endsequence
    property p_sub_zero;
        cmd_valid |-> cmd_sub == ROOT_SUB;
    endproperty
    property p_probe_addr;
        cmd_valid && cmd_code == RANGE_PROBE_COMMAND
            |-> cmd_dest == EVERY_NODE_ADDRESS && cmd_plen == PROBE_PARAM_LEN;
    endproperty
    property p_probe_tx;
        s_probe_take ##1 line_active |-> ##1 rsp_valid;
    endproperty
    property p_probe_first;
        s_probe_take ##2 rsp_valid |-> rsp_data == PREAMBLE_BYTE;
    endproperty
    property p_ack_byte;
        s_mute_take ##2 rsp_valid |-> rsp_data == ACK_BYTE && !rsp_last;
    endproperty
    property p_tx_on;
        rsp_valid |-> line_active;
    endproperty
    property p_preamble;
        take && idx_reg inside {[2:6]} |-> rsp_data == PREAMBLE_BYTE;
    endproperty
    property p_sep;
        take && idx_reg == 5'h07 |-> rsp_data == SEPARATOR_BYTE && !rsp_last;
    endproperty
    property p_enc;
        take && idx_reg >= 5'h08 |-> (rsp_data & enc_mask) == enc_mask;
    endproperty
    property p_last_slot;
        take && rsp_last |-> idx_reg == 5'h17 || idx_reg == 5'h01;
    endproperty
    a_sub_zero: assert property (p_sub_zero)
        else $error("command not aimed at root device");
    a_probe_addr: assert property (p_probe_addr)
        else $error("probe destination or length wrong");
    a_probe_tx: assert property (p_probe_tx)
        else $error("transmitter on without first reply byte");
    a_probe_first: assert property (p_probe_first)
        else $error("probe reply does not open with preamble");
    a_ack_byte: assert property (p_ack_byte)
        else $error("silence reply byte wrong");
    a_tx_on: assert property (p_tx_on)
        else $error("reply byte while transmitter off");
    a_preamble: assert property (p_preamble)
        else $error("preamble byte wrong");
    a_sep: assert property (p_sep)
        else $error("separator byte wrong");
    a_enc: assert property (p_enc)
        else $error("encoded byte lacks its mask bits");
    a_last_slot: assert property (p_last_slot)
        else $error("reply length wrong");
endmodule

//--- bench/uid_discovery_responder_tb.sv
`timescale 1ns/1ps
module uid_discovery_responder_tb;
    import udr_pkg::*;
    localparam int WIN = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic rsp_stall = 1'b0;
    logic soft_reset = 1'b0;
    logic [47:0] uid = 48'h0;
    logic muted;
    logic reply_busy;
    logic found_valid;
    logic [47:0] found_uid;
    logic busy;
    logic done;
    logic [47:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 774;
    int stall_left = 0;
    udr_link_if link();
    udr_responder i_udr_responder (.clk(clk), .rst_n(rst_n), .link(link), .uid(uid),
        .soft_reset(soft_reset), .muted(muted), .reply_busy(reply_busy));
    udr_controller #(.WINDOW_CYC(WIN)) i_udr_controller (.clk(clk), .rst_n(rst_n), .link(link),
        .start(start), .rsp_stall(rsp_stall), .found_valid(found_valid),
        .found_uid(found_uid), .busy(busy), .done(done));
    udr_checker i_udr_checker (.clk(clk), .rst_n(rst_n), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .cmd_code(link.cmd_code), .cmd_dest(link.cmd_dest),
        .cmd_sub(link.cmd_sub), .cmd_plen(link.cmd_plen), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last),
        .line_active(link.line_active));
    always #5 clk = ~clk;
    // Random stalls, plus a long one that fills the reply buffer
    always @(posedge clk) begin
        rsp_stall <= stall_left != 0 || ($random(seed) & 3) == 0;
        if (stall_left != 0) begin
            stall_left <= stall_left - 1;
        end
    end
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    always @(negedge clk) begin
        if (found_valid === 1'b1) begin
            check("found_uid", exp_q.size() ? exp_q.pop_front() : 48'hx, found_uid);
        end
    end
    // How: 0 soft reset, 1 hardware reset, 2 left muted for the next search
    task automatic run_one(input logic [47:0] id, input int stall, input int how);
        int n;
        @(posedge clk);
        uid <= id;
        stall_left <= stall;
        exp_q.push_back(id);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check("busy", 48'h1, {47'h0, busy});
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", 48'h1, {47'h0, done});
        check("finds left", 48'h0, 48'(exp_q.size()));
        check("muted", 48'h1, {47'h0, muted});
        check("busy idle", 48'h0, {47'h0, busy});
        check("reply_busy", 48'h0, {47'h0, reply_busy});
        @(posedge clk);
        if (how == 0) begin
            soft_reset <= 1'b1;
            @(posedge clk);
            soft_reset <= 1'b0;
        end else if (how == 1) begin
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
        end
        @(posedge clk);
        #1;
        if (how < 2) begin
            check("muted cleared", 48'h0, {47'h0, muted});
        end
        $display("test uid %h ended after %0d cycles", id, n);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        run_one(48'h0000_0000_0000, 0, 2);
        run_one(48'hffff_ffff_fffe, 60, 1);
        for (int i = 0; i < 6; i++) begin
            run_one({16'($random(seed)), 32'($random(seed))}, i * 10, i % 3);
        end
        give_verdict();
    end
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
endmodule
